// file: pkg/cbr_cfg.svh
`ifndef CBR_CFG_SVH
`define CBR_CFG_SVH

// register byte addresses on the serial bus
`define CBR_ADDR_CLK_CFG    8'h06
`define CBR_ADDR_BR_DIV     8'h07
`define CBR_ADDR_SCR_SEED   8'h08
`define CBR_ADDR_A_INT      8'h09
`define CBR_ADDR_A_FRAC0    8'h0a
`define CBR_ADDR_A_FRAC1    8'h0b
`define CBR_ADDR_A_FRAC2    8'h0c
`define CBR_ADDR_B_INT      8'h0d
`define CBR_ADDR_B_FRAC0    8'h0e
`define CBR_ADDR_B_FRAC1    8'h0f
`define CBR_ADDR_B_FRAC2    8'h10
`define CBR_ADDR_C_INT      8'h11
`define CBR_ADDR_C_FRAC0    8'h12
`define CBR_ADDR_C_FRAC1    8'h13
`define CBR_ADDR_C_FRAC2    8'h14
`define CBR_NUM_REGS        15

// clock_out_config field positions
`define CBR_SRC_HI          7
`define CBR_SRC_LO          6
`define CBR_POST_HI         5
`define CBR_POST_LO         4
`define CBR_PRE_HI          3
`define CBR_PRE_LO          1
`define CBR_ON_BIT          0

// reset values
`define CBR_RST_CLK_CFG     8'h09
`define CBR_RST_BR_DIV      8'h80
`define CBR_RST_SCR_SEED    8'hab
`define CBR_RST_INT         8'h40
`define CBR_RST_FRAC_LOW    8'h00
`define CBR_RST_FRAC_HIGH   8'h10

// writable bit masks
`define CBR_MASK_INT        8'h7f
`define CBR_MASK_FRAC_HIGH  8'h1f
`define CBR_MASK_FULL       8'hff

// default clock after the strap: divide by 16, pre-scaler source
`define CBR_AUTO_PRE        3'h4
`define CBR_AUTO_POST       2'h0
`define CBR_AUTO_SRC        2'h0

// serial frame: command byte then one data byte
`define CBR_CMD_LAST_BIT    5'h07
`define CBR_DATA_LAST_BIT   5'h0f
`define CBR_RW_BIT          7

`endif

// file: pkg/cbr_pkg.sv
package cbr_pkg;
  typedef enum logic [1:0] {
    CBR_IDLE = 2'b00,
    CBR_CMD  = 2'b01,
    CBR_DATA = 2'b10,
    CBR_DONE = 2'b11
  } cbr_spi_state_t;

  typedef logic [7:0] cbr_byte_t;
endpackage

// file: verilog/cbr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbr_cfg.svh"
// Contract
// - clock source 00 pre, 01 bit-rate clock, 10 its inverse, 11 post clock
// - post-scaler divides by 1, 2, 4 or 8 for codes 0 to 3
// - pre-scaler divides the crystal clock by two to the code
// - enable low: pin shows oscillator-stable level; high: selected clock
// - data input low at first enable rise forces output on at divide 16
// - bit rate is crystal over pre times divisor+1 times post; the bit-rate clock runs at half that
// - bit-rate divisor is eight bits, codes map straight to 0..255
// - scrambler loads its seed at the start of every transmission
// - fractional ratio is 21 bits over low, middle and five high bits
// - integer offset is seven bits 6:0, bit 7 unused
module cbr_regs #(
  parameter int SCR_W = 8
) (
  input wire logic sys_clk, // crystal clock, 100 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic spi_en, // serial enable pin, frame while high
  input wire logic spi_sck, // serial clock pin
  input wire logic spi_sdio_in, // serial data pin, input side
  output logic spi_sdio_out, // serial data pin, output side
  output logic spi_sdio_oe_n, // low while this block drives data
  input wire logic xosc_stable, // oscillator stable level, asynchronous
  input wire logic tx_start, // one-cycle pulse, transmission begins
  output logic clock_out_pin, // divided clock output
  output logic bit_tick, // one-cycle pulse per data bit
  output logic scram_bit, // scrambler output bit
  output logic [6:0] chan_a_int_offset, // channel a integer offset
  output logic [6:0] chan_b_int_offset, // channel b integer offset
  output logic [6:0] chan_c_int_offset, // channel c integer offset
  output logic [20:0] chan_a_frac, // channel a fractional ratio
  output logic [20:0] chan_b_frac, // channel b fractional ratio
  output logic [20:0] chan_c_frac // channel c fractional ratio
);
  import cbr_pkg::*;

  if (SCR_W != 8) begin : g_chk
    $error("cbr_regs: scrambler width must be 8");
  end

  function automatic cbr_byte_t reg_mask(input logic [7:0] addr);
    case (addr)
      `CBR_ADDR_A_INT, `CBR_ADDR_B_INT, `CBR_ADDR_C_INT: reg_mask = `CBR_MASK_INT;
      `CBR_ADDR_A_FRAC2, `CBR_ADDR_B_FRAC2, `CBR_ADDR_C_FRAC2: reg_mask = `CBR_MASK_FRAC_HIGH;
      default: reg_mask = `CBR_MASK_FULL;
    endcase
  endfunction

  function automatic cbr_byte_t reg_reset(input logic [7:0] addr);
    case (addr)
      `CBR_ADDR_CLK_CFG: reg_reset = `CBR_RST_CLK_CFG;
      `CBR_ADDR_BR_DIV: reg_reset = `CBR_RST_BR_DIV;
      `CBR_ADDR_SCR_SEED: reg_reset = `CBR_RST_SCR_SEED;
      `CBR_ADDR_A_INT, `CBR_ADDR_B_INT, `CBR_ADDR_C_INT: reg_reset = `CBR_RST_INT;
      `CBR_ADDR_A_FRAC2, `CBR_ADDR_B_FRAC2, `CBR_ADDR_C_FRAC2: reg_reset = `CBR_RST_FRAC_HIGH;
      default: reg_reset = `CBR_RST_FRAC_LOW;
    endcase
  endfunction

  // all-ones mask of 'code' bits: a counter matching it wraps every 2**code
  function automatic logic [6:0] div_mask(input logic [2:0] code);
    div_mask = 7'((8'h01 << code) - 8'h01);
  endfunction

  // array slot of a register; callers keep addr inside the bank
  function automatic logic [3:0] reg_idx(input logic [7:0] addr);
    reg_idx = 4'(addr - `CBR_ADDR_CLK_CFG);
  endfunction

  // pin synchronisers; stage 1 feeds stage 2 only
  logic en_s1_q, en_s2_q, en_s3_q;
  logic sck_s1_q, sck_s2_q, sck_s3_q;
  logic sdi_s1_q, sdi_s2_q;
  logic xo_s1_q, xo_s2_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {en_s1_q, en_s2_q, en_s3_q} <= 3'h0;
      {sck_s1_q, sck_s2_q, sck_s3_q} <= 3'h0;
      {sdi_s1_q, sdi_s2_q, xo_s1_q, xo_s2_q} <= 4'h0;
    end else begin
      {en_s1_q, en_s2_q, en_s3_q} <= {spi_en, en_s1_q, en_s2_q};
      {sck_s1_q, sck_s2_q, sck_s3_q} <= {spi_sck, sck_s1_q, sck_s2_q};
      {sdi_s1_q, sdi_s2_q, xo_s1_q, xo_s2_q} <= {spi_sdio_in, sdi_s1_q, xosc_stable, xo_s1_q};
    end
  end

  wire en_rise = en_s2_q & ~en_s3_q;
  wire sck_rise = sck_s2_q & ~sck_s3_q;
  wire sck_fall = ~sck_s2_q & sck_s3_q;

  // register file and serial slave
  cbr_byte_t regs_q [`CBR_NUM_REGS];
  cbr_spi_state_t state_q;
  logic [4:0] bit_cnt_q;
  cbr_byte_t shift_q, cmd_q, rd_q;
  logic sdo_q, oe_n_q;

  wire [7:0] in_byte = {shift_q[6:0], sdi_s2_q};
  wire cmd_read = in_byte[`CBR_RW_BIT];
  wire [7:0] cmd_addr = {1'b0, in_byte[6:0]};
  wire [7:0] data_addr = {1'b0, cmd_q[6:0]};
  wire cmd_hit = (cmd_addr >= `CBR_ADDR_CLK_CFG) && (cmd_addr <= `CBR_ADDR_C_FRAC2);
  wire data_hit = (data_addr >= `CBR_ADDR_CLK_CFG) && (data_addr <= `CBR_ADDR_C_FRAC2);
  wire [3:0] cmd_idx = reg_idx(cmd_addr);
  wire [3:0] wr_idx = reg_idx(data_addr);
  wire [7:0] rd_data = cmd_hit ? regs_q[cmd_idx] : 8'h00;
  wire wr_en = (state_q == CBR_DATA) && sck_rise && (bit_cnt_q == `CBR_DATA_LAST_BIT) &&
               ~cmd_q[`CBR_RW_BIT] && data_hit;
  // bits 7:5 of the high fractional bytes are never stored
  wire [7:0] wr_data = in_byte & reg_mask(data_addr);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= CBR_IDLE;
      bit_cnt_q <= 5'h00;
      shift_q <= 8'h00;
      cmd_q <= 8'h00;
      rd_q <= 8'h00;
      sdo_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else if (!en_s2_q) begin
      state_q <= CBR_IDLE;
      oe_n_q <= 1'b1;
    end else begin
      case (state_q)
        CBR_IDLE: begin
          state_q <= CBR_CMD;
          bit_cnt_q <= 5'h00;
        end
        CBR_CMD, CBR_DATA: begin
          if (sck_rise) begin
            shift_q <= in_byte;
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (state_q == CBR_CMD && bit_cnt_q == `CBR_CMD_LAST_BIT) begin
              state_q <= CBR_DATA;
              cmd_q <= in_byte;
              rd_q <= {rd_data[6:0], 1'b0};
              sdo_q <= rd_data[7];
              oe_n_q <= ~cmd_read;
            end
            if (state_q == CBR_DATA && bit_cnt_q == `CBR_DATA_LAST_BIT) begin
              state_q <= CBR_DONE;
            end
          end
          if (sck_fall && state_q == CBR_DATA && bit_cnt_q != 5'h08) begin
            sdo_q <= rd_q[7];
            rd_q <= {rd_q[6:0], 1'b0};
          end
        end
        CBR_DONE: oe_n_q <= 1'b1;
        default: state_q <= CBR_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < `CBR_NUM_REGS; i++) begin
      if (rst) begin
        regs_q[i] <= reg_reset(8'(i + `CBR_ADDR_CLK_CFG));
      end else if (wr_en && wr_idx == 4'(i)) begin
        regs_q[i] <= wr_data;
      end
    end
  end

  // index the array directly: a function reading regs_q would hide it from the sensitivity
  wire cbr_byte_t clk_cfg = regs_q[reg_idx(`CBR_ADDR_CLK_CFG)];
  wire cbr_byte_t br_div = regs_q[reg_idx(`CBR_ADDR_BR_DIV)];
  wire cbr_byte_t scr_seed = regs_q[reg_idx(`CBR_ADDR_SCR_SEED)];

  assign chan_a_int_offset = regs_q[reg_idx(`CBR_ADDR_A_INT)][6:0];
  assign chan_b_int_offset = regs_q[reg_idx(`CBR_ADDR_B_INT)][6:0];
  assign chan_c_int_offset = regs_q[reg_idx(`CBR_ADDR_C_INT)][6:0];
  assign chan_a_frac = {regs_q[reg_idx(`CBR_ADDR_A_FRAC2)][4:0],
                        regs_q[reg_idx(`CBR_ADDR_A_FRAC1)],
                        regs_q[reg_idx(`CBR_ADDR_A_FRAC0)]};
  assign chan_b_frac = {regs_q[reg_idx(`CBR_ADDR_B_FRAC2)][4:0],
                        regs_q[reg_idx(`CBR_ADDR_B_FRAC1)],
                        regs_q[reg_idx(`CBR_ADDR_B_FRAC0)]};
  assign chan_c_frac = {regs_q[reg_idx(`CBR_ADDR_C_FRAC2)][4:0],
                        regs_q[reg_idx(`CBR_ADDR_C_FRAC1)],
                        regs_q[reg_idx(`CBR_ADDR_C_FRAC0)]};

  // strap: only the first enable rise after reset counts
  logic seen_en_q, auto_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seen_en_q <= 1'b0;
      auto_q <= 1'b0;
    end else if (en_rise && !seen_en_q) begin
      seen_en_q <= 1'b1;
      auto_q <= ~sdi_s2_q;
    end else if (wr_en && data_addr == `CBR_ADDR_CLK_CFG) begin
      auto_q <= 1'b0; // host takes over once it programs the clock
    end
  end

  wire clock_on = clk_cfg[`CBR_ON_BIT] | auto_q;
  wire [2:0] pre_sel = auto_q ? `CBR_AUTO_PRE : clk_cfg[`CBR_PRE_HI:`CBR_PRE_LO];
  wire [1:0] post_sel = auto_q ? `CBR_AUTO_POST : clk_cfg[`CBR_POST_HI:`CBR_POST_LO];
  wire [1:0] src_sel = auto_q ? `CBR_AUTO_SRC : clk_cfg[`CBR_SRC_HI:`CBR_SRC_LO];

  // divider chain; pre and post clocks are one-cycle pulses, so divide by 1
  // shows as a steady high level: a limitation of a single-clock design
  logic [6:0] pre_cnt_q;
  logic [2:0] post_cnt_q;
  logic [7:0] br_cnt_q;
  logic br_clk_q, clk_out_q;
  wire [6:0] pre_m = div_mask(pre_sel);
  wire [2:0] post_m = 3'(div_mask({1'b0, post_sel}));
  wire pre_tick = (pre_cnt_q & pre_m) == pre_m;
  wire post_tick = pre_tick && ((post_cnt_q & post_m) == post_m);
  wire br_wrap = post_tick && (br_cnt_q == br_div);
  assign bit_tick = br_wrap;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pre_cnt_q <= 7'h00;
      post_cnt_q <= 3'h0;
      br_cnt_q <= 8'h00;
      br_clk_q <= 1'b0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 7'h01;
      if (pre_tick) begin
        post_cnt_q <= post_cnt_q + 3'h1;
      end
      if (post_tick) begin
        br_cnt_q <= br_wrap ? 8'h00 : br_cnt_q + 8'h01;
      end
      if (br_wrap) begin
        br_clk_q <= ~br_clk_q;
      end
    end
  end

  logic sel_clk;
  always_comb begin
    case (src_sel)
      2'b00: sel_clk = pre_tick;
      2'b01: sel_clk = br_clk_q;
      2'b10: sel_clk = ~br_clk_q;
      2'b11: sel_clk = post_tick;
      default: sel_clk = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clk_out_q <= 1'b0;
    end else begin
      clk_out_q <= clock_on ? sel_clk : xo_s2_q;
    end
  end

  // scrambler, x^8 + x^6 + x^5 + x^4 + 1, one step per data bit
  logic [SCR_W-1:0] lfsr_q;
  wire lfsr_fb = lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3];
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lfsr_q <= `CBR_RST_SCR_SEED;
    end else if (tx_start) begin
      lfsr_q <= scr_seed;
    end else if (br_wrap) begin
      lfsr_q <= {lfsr_q[6:0], lfsr_fb};
    end
  end

  assign scram_bit = lfsr_q[7];
  assign clock_out_pin = clk_out_q;
  assign spi_sdio_out = sdo_q;
  assign spi_sdio_oe_n = oe_n_q;

  property p_src_inv;
    @(posedge sys_clk) disable iff (rst)
    clock_on && src_sel == 2'b10 |=> clk_out_q == !$past(br_clk_q);
  endproperty
  a_src_inv: assert property (p_src_inv) else $error("inverted source wrong");

  property p_post1;
    @(posedge sys_clk) disable iff (rst)
    post_sel == 2'b00 && pre_tick |-> post_tick;
  endproperty
  a_post1: assert property (p_post1) else $error("post divide by 1 wrong");

  property p_post8;
    @(posedge sys_clk) disable iff (rst)
    post_sel == 2'b11 && post_tick |=> (!post_tick || post_sel != 2'b11) [*7];
  endproperty
  a_post8: assert property (p_post8) else $error("post divide by 8 wrong");

  property p_pre1;
    @(posedge sys_clk) disable iff (rst)
    pre_sel == 3'h0 |-> pre_tick;
  endproperty
  a_pre1: assert property (p_pre1) else $error("pre divide by 1 wrong");

  property p_off;
    @(posedge sys_clk) disable iff (rst)
    !clock_on |=> clk_out_q == $past(xo_s2_q);
  endproperty
  a_off: assert property (p_off) else $error("disabled output not stable flag");

  property p_strap;
    @(posedge sys_clk) disable iff (rst)
    en_rise && !seen_en_q && !sdi_s2_q |=> auto_q && clock_on && pre_m == 7'h0f;
  endproperty
  a_strap: assert property (p_strap) else $error("strap did not enable clock");

  property p_wrap;
    @(posedge sys_clk) disable iff (rst)
    br_wrap |=> br_cnt_q == 8'h00 && br_clk_q != $past(br_clk_q);
  endproperty
  a_wrap: assert property (p_wrap) else $error("bit-rate wrap wrong");

  property p_count;
    @(posedge sys_clk) disable iff (rst)
    post_tick && !br_wrap |=> br_cnt_q == $past(br_cnt_q) + 8'h01;
  endproperty
  a_count: assert property (p_count) else $error("bit-rate count wrong");

  property p_seed;
    @(posedge sys_clk) disable iff (rst)
    tx_start |=> lfsr_q == $past(scr_seed);
  endproperty
  a_seed: assert property (p_seed) else $error("scrambler seed not loaded");

  property p_frac_hi;
    @(posedge sys_clk) disable iff (rst)
    wr_en && data_addr == `CBR_ADDR_A_FRAC2 |=> chan_a_frac[20:16] == $past(in_byte[4:0]);
  endproperty
  a_frac_hi: assert property (p_frac_hi) else $error("frac high byte wrong");

  property p_int;
    @(posedge sys_clk) disable iff (rst)
    wr_en && data_addr == `CBR_ADDR_B_INT |=> chan_b_int_offset == $past(in_byte[6:0]);
  endproperty
  a_int: assert property (p_int) else $error("integer offset write wrong");
endmodule
`default_nettype wire

// file: verilog/cbr_fix_note.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: test/cbr_host.sv
`timescale 1ns/1ps
`default_nettype none
module cbr_host #(
  parameter int HP = 5
) (
  input wire logic sys_clk, // crystal clock
  input wire logic sdio_w, // resolved data line
  output logic spi_en, // frame enable
  output logic spi_sck, // serial clock
  output logic host_d, // data bit driven by the host
  output logic host_oe // high while the host drives data
);
  initial begin
    spi_en = 1'b0;
    spi_sck = 1'b0;
    host_d = 1'b1;
    host_oe = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // nb below 16 drops enable early, aborting the frame
  task automatic xfer(input logic rw, input logic [6:0] addr, input logic [7:0] wd,
                      input int nb, output logic [7:0] rdat);
    logic [15:0] sh;
    logic [7:0] wv;
    wv = wd;
    if (!rw && (addr == 7'h0c || addr == 7'h10 || addr == 7'h14)) wv[5] = 1'b0;
    sh = {rw, addr, wv};
    rdat = 8'h00;
    @(negedge sys_clk);
    host_d = sh[15];
    wait_clk(HP);
    spi_en = 1'b1;
    for (int i = 0; i < nb; i++) begin
      host_oe = !(rw && i >= 8);
      if (host_oe) host_d = sh[15 - i];
      wait_clk(HP);
      spi_sck = 1'b1;
      if (i >= 8) rdat[15 - i] = sdio_w;
      wait_clk(HP);
      spi_sck = 1'b0;
    end
    wait_clk(HP);
    host_oe = 1'b1;
    spi_en = 1'b0;
    wait_clk(2 * HP);
  endtask
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cbr_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic xosc_stable = 1'b1;
  logic tx_start = 1'b0;
  logic spi_en, spi_sck, host_d, host_oe, sdio_w, sdio_out, oe_n;
  logic clock_out_pin, bit_tick, scram_bit;
  logic [6:0] ia, ib, ic;
  logic [20:0] fa, fb, fc;
  int n_fail = 0;
  int n_checks = 0;
  int hi, tk, tg;
  cbr_byte_t model [int];
  cbr_byte_t rd, s;
  int cfg [6][3] = '{'{0,0,0}, '{1,1,2}, '{2,3,4}, '{0,0,255}, '{3,0,9}, '{1,2,1}};
  always #5 sys_clk = ~sys_clk;
  // a released line shows the inverse of the last host bit, never a stale match
  assign sdio_w = !oe_n ? sdio_out : (host_oe ? host_d : ~host_d);
  cbr_regs u_cbr_regs (.sys_clk(sys_clk), .rst(rst), .spi_en(spi_en), .spi_sck(spi_sck),
    .spi_sdio_in(sdio_w), .spi_sdio_out(sdio_out), .spi_sdio_oe_n(oe_n),
    .xosc_stable(xosc_stable), .tx_start(tx_start), .clock_out_pin(clock_out_pin),
    .bit_tick(bit_tick), .scram_bit(scram_bit), .chan_a_int_offset(ia),
    .chan_b_int_offset(ib), .chan_c_int_offset(ic), .chan_a_frac(fa),
    .chan_b_frac(fb), .chan_c_frac(fc));
  cbr_host u_cbr_host (.sys_clk(sys_clk), .sdio_w(sdio_w), .spi_en(spi_en),
    .spi_sck(spi_sck), .host_d(host_d), .host_oe(host_oe));
  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic cbr_byte_t msk(input int a);
    if (a == 9 || a == 13 || a == 17) return 8'h7f;
    if (a == 12 || a == 16 || a == 20) return 8'h1f;
    return 8'hff;
  endfunction
  task automatic wr(input int a, input cbr_byte_t d);
    u_cbr_host.xfer(1'b0, a[6:0], d, 16, rd);
    if (model.exists(a)) model[a] = d & msk(a);
  endtask
  task automatic rdc(input int a);
    u_cbr_host.xfer(1'b1, a[6:0], 8'h00, 16, rd);
    chk(rd, model.exists(a) ? model[a] : 8'h00);
  endtask
  task automatic count(input int n);
    logic l;
    hi = 0;
    tk = 0;
    tg = 0;
    l = clock_out_pin;
    repeat (n) begin
      @(negedge sys_clk);
      hi += int'(clock_out_pin);
      tk += int'(bit_tick);
      tg += int'(clock_out_pin != l);
      l = clock_out_pin;
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    for (int a = 6; a <= 20; a++) model[a] = a % 4 == 0 ? 8'h10 : (a % 4 == 1 ? 8'h40 : 8'h00);
    model[6] = 8'h09;
    model[7] = 8'h80;
    model[8] = 8'hab;
  endtask
  initial begin
    void'($urandom(89948));
    do_reset();
    wr(8, 8'hab);
    count(256);
    chk(hi, 16);
    for (int a = 5; a <= 21; a++) rdc(a);
    for (int a = 6; a <= 20; a++) wr(a, cbr_byte_t'($urandom));
    for (int a = 6; a <= 20; a++) rdc(a);
    chk(ia, model[9][6:0]);
    chk(ib, model[13][6:0]);
    chk(ic, model[17][6:0]);
    chk(fa, {model[12][4:0], model[11], model[10]});
    chk(fb, {model[16][4:0], model[15], model[14]});
    chk(fc, {model[20][4:0], model[19], model[18]});
    wr(32, 8'h5a);
    rdc(32);
    u_cbr_host.xfer(1'b0, 7'h08, ~model[8], 12, rd);
    rdc(8);
    for (int p = 0; p < 8; p++) begin
      wr(6, {4'h0, p[2:0], 1'b1});
      count(300);
      count(256);
      chk(hi, 256 >> p);
    end
    for (int q = 0; q < 4; q++) begin
      wr(6, {2'b11, q[1:0], 3'h1, 1'b1});
      count(300);
      count(256);
      chk(hi, 128 >> q);
    end
    for (int i = 0; i < 6; i++) begin
      int per;
      per = (cfg[i][2] + 1) << (cfg[i][0] + cfg[i][1]);
      wr(7, 8'(cfg[i][2]));
      wr(6, {i[0] ? 2'b10 : 2'b01, 2'(cfg[i][1]), 3'(cfg[i][0]), 1'b1});
      count(2600);
      count(8 * per);
      chk(tk, 8);
      chk(tg, 8);
      chk(hi, 4 * per);
    end
    xosc_stable = 1'b0;
    wr(6, 8'h08);
    count(20);
    chk(hi, 0);
    xosc_stable = 1'b1;
    count(5);
    count(20);
    chk(hi, 20);
    // slowest bit clock so the sequence does not step while checked
    wr(7, 8'hff);
    wr(6, 8'hff);
    s = cbr_byte_t'($urandom);
    repeat (4) begin
      s ^= 8'h80;
      wr(8, s);
      tx_start = 1'b1;
      @(negedge sys_clk);
      tx_start = 1'b0;
      @(negedge sys_clk);
      chk(scram_bit, s[7]);
    end
    do_reset();
    rdc(7);
    rdc(12);
    close_out();
  end
  initial begin
    #900000;
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
